// >>> design/gpp_map.svh
// register-free constants for the general purpose io port
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH
`define GPP_PINS             8
`define GPP_VEC_BASE         12'h044
`define GPP_VEC_STRIDE       12'h002
`define GPP_OPC_SET_VAL      3'h0
`define GPP_OPC_CLR_VAL      3'h1
`define GPP_OPC_TGL_VAL      3'h2
`define GPP_OPC_SET_DIR      3'h3
`define GPP_OPC_CLR_DIR      3'h4
`define GPP_OPC_TGL_DIR      3'h5
`define GPP_OPC_WR_VAL       3'h6
`define GPP_OPC_WR_DIR       3'h7
`define GPP_SYNC_STAGES      2
`endif

// >>> design/gpp_pkg.sv
// types for the general purpose io port
package gpp_pkg;
    typedef enum logic [1:0] {GPP_SENSE_BOTH, GPP_SENSE_RISE, GPP_SENSE_FALL, GPP_SENSE_LOW} gpp_sense_t;
    typedef enum logic [2:0] {GPP_DRV_TOTEM, GPP_DRV_BUSKEEP, GPP_DRV_PULLDN, GPP_DRV_PULLUP,
                              GPP_DRV_WOR, GPP_DRV_WAND, GPP_DRV_WOR_PD, GPP_DRV_WAND_PU} gpp_drive_t;
    typedef enum logic [1:0] {GPP_OUT_NONE, GPP_OUT_PERCLK, GPP_OUT_RTCCLK, GPP_OUT_EVENT} gpp_clkout_t;
    typedef struct packed {
        gpp_drive_t drive;
        logic       invert;
        gpp_sense_t sense;
    } gpp_pincfg_t;
    typedef struct packed {
        logic       valid;
        logic [2:0] opcode;
        logic [7:0] mask;
    } gpp_access_t;
endpackage

// >>> design/gpp_sense.sv
// per-pin input sense cell: synchroniser, edge and level detection
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_sense
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // pin and setting
    input  wire logic       pinIn,
    input  wire gpp_sense_t sense,
    input  wire logic       clkActive,
    // result
    output logic            hit,
    output logic            level
);
    logic syncA;
    logic syncB;
    logic prev;
    logic next_syncA;
    logic next_syncB;
    logic next_prev;

    always_comb begin
        next_syncA = pinIn;
        next_syncB = syncA;
        next_prev  = syncB;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            prev  <= 1'b0;
        end else begin
            syncA <= next_syncA;
            syncB <= next_syncB;
            prev  <= next_prev;
        end
    end

    // clock stopped: raw pin level steers the wake request instead
    logic cur;
    assign cur   = clkActive ? syncB : pinIn;
    assign level = syncB;

    always_comb begin
        case (sense)
            GPP_SENSE_BOTH: hit = clkActive ? (syncB ^ prev) : 1'b0;
            GPP_SENSE_RISE: hit = clkActive ? (syncB & ~prev) : 1'b0;
            GPP_SENSE_FALL: hit = clkActive ? (~syncB & prev) : 1'b0;
            GPP_SENSE_LOW:  hit = ~cur;
            default:        hit = 1'b0;
        endcase
    end

    rise_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkActive && sense == GPP_SENSE_RISE && $rose(syncB)) |-> hit)
        else $error("rising edge not reported");

    edge_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!clkActive && sense != GPP_SENSE_LOW) |-> !hit)
        else $error("edge reported with clock stopped");
endmodule

// >>> design/gpp_port.sv
// general purpose io port top: pin state, drive, sense, interrupts, outputs
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port
    import gpp_pkg::*;
#(
    parameter int PINS = `GPP_PINS,
    parameter logic [11:0] VEC_BASE = `GPP_VEC_BASE
)(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              clkActive,
    // software access
    input  gpp_access_t            access,
    input  wire logic [PINS-1:0]   wrData,
    input  wire logic              cfgWrite,
    input  gpp_pincfg_t            cfgData,
    input  wire logic [PINS-1:0]   cfgMask,
    input  wire logic [PINS-1:0]   irqMaskA,
    input  wire logic [PINS-1:0]   irqMaskB,
    // alternate functions and clock outputs
    input  wire logic [PINS-1:0]   altEn,
    input  wire logic [PINS-1:0]   altOut,
    input  wire logic [PINS-1:0]   altDirOut,
    input  wire logic              perClk,
    input  wire logic              rtcClk,
    input  wire logic              eventIn,
    input  gpp_clkout_t            clkOutSel,
    input  wire logic [2:0]        clkOutPin,
    input  wire logic [1:0]        remapSel,
    // pins
    input  wire logic [PINS-1:0]   pinIn,
    output logic      [PINS-1:0]   pinOut,
    output logic      [PINS-1:0]   pinOe,
    output logic      [PINS-1:0]   pullUpEn,
    output logic      [PINS-1:0]   pullDownEn,
    // status and requests
    output logic      [PINS-1:0]   outVal,
    output logic      [PINS-1:0]   dirVal,
    output logic      [PINS-1:0]   inVal,
    output logic      [PINS-1:0]   eventOut,
    output logic                   irqA,
    output logic                   irqB,
    output logic                   wake,
    output logic      [11:0]       vecA,
    output logic      [11:0]       vecB,
    output logic      [1:0]        remapLoc
);
    // ----------------------------------------------------------------
    // output and direction registers
    // ----------------------------------------------------------------
    logic [PINS-1:0]   next_outVal;
    logic [PINS-1:0]   next_dirVal;
    logic [PINS-1:0]   keepLvl;
    logic [PINS-1:0]   next_keepLvl;
    gpp_pincfg_t       cfg [PINS];
    gpp_pincfg_t       next_cfg [PINS];
    logic [PINS-1:0]   flagA;
    logic [PINS-1:0]   next_flagA;

    always_comb begin
        next_outVal = outVal;
        next_dirVal = dirVal;
        if (access.valid) begin
            case (access.opcode)
                `GPP_OPC_SET_VAL: next_outVal = outVal | access.mask[PINS-1:0];
                `GPP_OPC_CLR_VAL: next_outVal = outVal & ~access.mask[PINS-1:0];
                `GPP_OPC_TGL_VAL: next_outVal = outVal ^ access.mask[PINS-1:0];
                `GPP_OPC_SET_DIR: next_dirVal = dirVal | access.mask[PINS-1:0];
                `GPP_OPC_CLR_DIR: next_dirVal = dirVal & ~access.mask[PINS-1:0];
                `GPP_OPC_TGL_DIR: next_dirVal = dirVal ^ access.mask[PINS-1:0];
                `GPP_OPC_WR_VAL:  next_outVal = wrData;
                `GPP_OPC_WR_DIR:  next_dirVal = wrData;
                default:          next_outVal = outVal;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            outVal <= '0;
            dirVal <= '0;
        end else begin
            outVal <= next_outVal;
            dirVal <= next_dirVal;
        end
    end

    // ----------------------------------------------------------------
    // per-pin configuration, drive and sense
    // ----------------------------------------------------------------
    logic [PINS-1:0] drvLvl;
    logic [PINS-1:0] senseIn;
    logic [PINS-1:0] hit;
    logic [PINS-1:0] lvl;
    logic [PINS-1:0] clkPin;
    logic            clkSrc;

    always_comb begin
        case (clkOutSel)
            GPP_OUT_PERCLK: clkSrc = perClk;
            GPP_OUT_RTCCLK: clkSrc = rtcClk;
            GPP_OUT_EVENT:  clkSrc = eventIn;
            default:        clkSrc = 1'b0;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic       useAlt;
            logic       dOut;
            logic       drv;
            gpp_drive_t d;
            assign clkPin[i] = (clkOutSel != GPP_OUT_NONE) && (clkOutPin == 3'(i));
            assign useAlt    = altEn[i];
            assign dOut      = clkPin[i] ? clkSrc : (useAlt ? altOut[i] : outVal[i]);
            assign drv       = clkPin[i] | (useAlt ? altDirOut[i] : dirVal[i]);
            assign d         = cfg[i].drive;
            assign drvLvl[i] = dOut ^ cfg[i].invert;

            always_comb begin
                next_cfg[i] = cfg[i];
                if (cfgWrite && cfgMask[i]) begin
                    next_cfg[i] = cfgData;
                end
                next_keepLvl[i] = (drv && d == GPP_DRV_BUSKEEP) ? drvLvl[i] : keepLvl[i];
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cfg[i]     <= '{GPP_DRV_TOTEM, 1'b0, GPP_SENSE_BOTH};
                    keepLvl[i] <= 1'b0;
                end else begin
                    cfg[i]     <= next_cfg[i];
                    keepLvl[i] <= next_keepLvl[i];
                end
            end

            cfg_write_a: assert property (@(posedge ref_clk) disable iff (rst)
                (cfgWrite && cfgMask[i]) |=> (cfg[i] == $past(cfgData)))
                else $error("selected pin missed configuration write");

            cfg_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
                !(cfgWrite && cfgMask[i]) |=> (cfg[i] == $past(cfg[i])))
                else $error("unselected pin configuration changed");

            keep_track_a: assert property (@(posedge ref_clk) disable iff (rst)
                (drv && d == GPP_DRV_BUSKEEP) |=> (keepLvl[i] == $past(drvLvl[i])))
                else $error("bus-keeper lost last driven level");

            // wired modes drive only one level; in GPP_DRV_WOR_PD and GPP_DRV_WAND_PU the pull holds the other
            always_comb begin
                pinOut[i]     = drvLvl[i];
                pinOe[i]      = drv;
                pullUpEn[i]   = 1'b0;
                pullDownEn[i] = 1'b0;
                case (d)
                    GPP_DRV_TOTEM:   pinOe[i] = drv;
                    GPP_DRV_BUSKEEP: begin
                        pullUpEn[i]   = keepLvl[i];
                        pullDownEn[i] = ~keepLvl[i];
                    end
                    GPP_DRV_PULLDN:  pullDownEn[i] = ~drv;
                    GPP_DRV_PULLUP:  pullUpEn[i]   = ~drv;
                    GPP_DRV_WOR:     pinOe[i] = drv & drvLvl[i];
                    GPP_DRV_WAND:    pinOe[i] = drv & ~drvLvl[i];
                    GPP_DRV_WOR_PD:  begin
                        pinOe[i]      = drv & drvLvl[i];
                        pullDownEn[i] = 1'b1;
                    end
                    GPP_DRV_WAND_PU: begin
                        pinOe[i]      = drv & ~drvLvl[i];
                        pullUpEn[i]   = 1'b1;
                    end
                    default:         pinOe[i] = 1'b0;
                endcase
            end

            wired_or_a: assert property (@(posedge ref_clk) disable iff (rst)
                (d == GPP_DRV_WOR && !drvLvl[i]) |-> !pinOe[i])
                else $error("wired-or pin drove a low level");

            wired_and_a: assert property (@(posedge ref_clk) disable iff (rst)
                (d == GPP_DRV_WAND && drvLvl[i]) |-> !pinOe[i])
                else $error("wired-and pin drove a high level");

            clk_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
                (clkPin[i] && d == GPP_DRV_TOTEM) |-> (pinOe[i] && pinOut[i] == (clkSrc ^ cfg[i].invert)))
                else $error("clock output missing on selected pin");

            alt_over_a: assert property (@(posedge ref_clk) disable iff (rst)
                (altEn[i] && !clkPin[i] && d == GPP_DRV_TOTEM) |-> (pinOe[i] == altDirOut[i]))
                else $error("alternate direction not applied");

            assign senseIn[i] = pinIn[i] ^ cfg[i].invert;

            gpp_sense gpp_sense_inst (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .pinIn     (senseIn[i]),
                .sense     (cfg[i].sense),
                .clkActive (clkActive),
                .hit       (hit[i]),
                .level     (lvl[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupts, events and wake
    // ----------------------------------------------------------------
    logic [PINS-1:0] flagB;
    logic [PINS-1:0] next_flagB;
    logic [PINS-1:0] next_inVal;
    logic [PINS-1:0] next_eventOut;

    // flags follow the sensed condition; a held request clears when the pin settles
    always_comb begin
        next_flagA    = hit & irqMaskA;
        next_flagB    = hit & irqMaskB;
        next_inVal    = lvl;
        next_eventOut = hit;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flagA    <= '0;
            flagB    <= '0;
            inVal    <= '0;
            eventOut <= '0;
        end else begin
            flagA    <= next_flagA;
            flagB    <= next_flagB;
            inVal    <= next_inVal;
            eventOut <= next_eventOut;
        end
    end

    event_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
        (hit != '0) |=> (eventOut == $past(hit)))
        else $error("event output missed a sensed condition");

    assign irqA = |flagA;
    assign irqB = |flagB;
    // level request straight from the pin path; no clock needed to raise it
    assign wake = ~clkActive & |(hit & (irqMaskA | irqMaskB));
    assign vecA = VEC_BASE;
    assign vecB = 12'(VEC_BASE + `GPP_VEC_STRIDE);
    assign remapLoc = remapSel;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence setReq;
        access.valid && access.opcode == `GPP_OPC_SET_VAL;
    endsequence

    set_only_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        setReq |=> (outVal == ($past(outVal) | $past(access.mask[PINS-1:0]))))
        else $error("set access changed unselected bits");

    dir_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (access.valid && access.opcode == `GPP_OPC_SET_DIR) |=>
        ((dirVal & ~$past(access.mask[PINS-1:0])) == ($past(dirVal) & ~$past(access.mask[PINS-1:0]))))
        else $error("direction of other pins changed");

    irq_a_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        ((hit & irqMaskA) != '0) |=> irqA)
        else $error("masked pin did not raise request a");

    irq_b_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        ((hit & irqMaskB) == '0) |=> !irqB)
        else $error("request b without masked hit");

    vec_base_a: assert property (@(posedge ref_clk) disable iff (rst)
        vecB == vecA + `GPP_VEC_STRIDE)
        else $error("vector spacing wrong");

    wake_async_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!clkActive && (hit & irqMaskA) != '0) |-> wake)
        else $error("no wake with clock stopped");
endmodule

// >>> sim/gpp_ext_pins.sv
// external circuitry model on the port pins
`timescale 1ns/1ps
module gpp_ext_pins #(
    parameter int PINS = 8
)(
    // clock
    input  wire logic            ref_clk,
    // port side
    input  wire logic [PINS-1:0] pinOut,
    input  wire logic [PINS-1:0] pinOe,
    input  wire logic [PINS-1:0] pullUpEn,
    input  wire logic [PINS-1:0] pullDownEn,
    // outside drivers
    input  wire logic [PINS-1:0] extEn,
    input  wire logic [PINS-1:0] extVal,
    output logic      [PINS-1:0] pinLvl
);
    logic [PINS-1:0] lastLvl = '0;

    // a pin nobody holds flips each cycle, so a stale level never passes for a pull
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (pinOe[i])
                pinLvl[i] = pinOut[i];
            else if (extEn[i])
                pinLvl[i] = extVal[i];
            else if (pullUpEn[i])
                pinLvl[i] = 1'b1;
            else if (pullDownEn[i])
                pinLvl[i] = 1'b0;
            else
                pinLvl[i] = ~lastLvl[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        lastLvl <= pinLvl;
    end
endmodule

// >>> sim/gpp_port_test.sv
// self-checking bench for the general purpose io port
`timescale 1ns/1ps
`include "gpp_map.svh"
module gpp_port_test;
    import gpp_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clkActive = 1'b1;
    gpp_access_t access = '0;
    logic [7:0]  wrData = '0;
    logic        cfgWrite = 1'b0;
    gpp_pincfg_t cfgData = '0;
    logic [7:0]  cfgMask = '0, irqMaskA = '0, irqMaskB = '0;
    logic [7:0]  altEn = '0, altOut = '0, altDirOut = '0;
    logic        perClk = 1'b0, rtcClk = 1'b0, eventIn = 1'b0;
    gpp_clkout_t clkOutSel = GPP_OUT_NONE;
    logic [2:0]  clkOutPin = '0;
    logic [1:0]  remapSel = '0, remapLoc;
    logic [7:0]  extEn = 8'hFF, extVal = '0, pinIn, pinOut, pinOe, pullUpEn, pullDownEn;
    logic [7:0]  outVal, dirVal, inVal, eventOut;
    logic        irqA, irqB, wake;
    logic [11:0] vecA, vecB;
    int          mismatches = 0, cmp_count = 0;

    always #2.5 ref_clk = ~ref_clk;

    gpp_port gpp_port_inst (.ref_clk, .rst, .clkActive, .access, .wrData, .cfgWrite, .cfgData, .cfgMask,
        .irqMaskA, .irqMaskB, .altEn, .altOut, .altDirOut, .perClk, .rtcClk, .eventIn, .clkOutSel,
        .clkOutPin, .remapSel, .pinIn, .pinOut, .pinOe, .pullUpEn, .pullDownEn, .outVal, .dirVal,
        .inVal, .eventOut, .irqA, .irqB, .wake, .vecA, .vecB, .remapLoc);
    gpp_ext_pins gpp_ext_pins_inst (.ref_clk, .pinOut, .pinOe, .pullUpEn, .pullDownEn, .extEn, .extVal,
        .pinLvl(pinIn));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // leaves valid high so back-to-back requests never double-drive it
    task automatic acc(input logic [2:0] op, input logic [7:0] m, input logic [7:0] d);
        access = '{valid: 1'b1, opcode: op, mask: m};
        wrData = d;
        step(1);
    endtask
    task automatic cfg(input gpp_drive_t d, input logic inv, input gpp_sense_t s, input logic [7:0] m);
        cfgData = '{drive: d, invert: inv, sense: s};
        cfgMask = m;
        cfgWrite = 1'b1;
        step(1);
        cfgWrite = 1'b0;
        step(5);
    endtask
    task automatic count(output int n);
        n = 0;
        repeat (8) begin
            step(1);
            if (irqA === 1'b1) n++;
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_basic();
        chk("outVal", 12'h000, outVal);
        chk("dirVal", 12'h000, dirVal);
        chk("vecA", 12'h044, vecA);
        chk("vecB", 12'h046, vecB);
        acc(`GPP_OPC_WR_VAL, 8'hFF, 8'h5A);
        chk("outVal", 12'h05A, outVal);
        acc(`GPP_OPC_SET_VAL, 8'h81, 8'h00);
        chk("outVal", 12'h0DB, outVal);
        acc(`GPP_OPC_CLR_VAL, 8'h42, 8'h00);
        chk("outVal", 12'h099, outVal);
        acc(`GPP_OPC_TGL_VAL, 8'h0F, 8'h00);
        chk("outVal", 12'h096, outVal);
        acc(`GPP_OPC_WR_DIR, 8'hFF, 8'h0F);
        acc(`GPP_OPC_SET_DIR, 8'h10, 8'h00);
        chk("dirVal", 12'h01F, dirVal);
        acc(`GPP_OPC_CLR_DIR, 8'h01, 8'h00);
        chk("dirVal", 12'h01E, dirVal);
        acc(`GPP_OPC_TGL_DIR, 8'h21, 8'h00);
        access.valid = 1'b0;
        chk("dirVal", 12'h03F, dirVal);
        chk("pinOe", 12'h03F, pinOe);
        chk("pinOut", 12'h016, pinOut & dirVal);
    endtask
    task automatic t_cfg();
        cfg(GPP_DRV_PULLUP, 1'b0, GPP_SENSE_BOTH, 8'hC0);
        chk("pullUpEn", 12'h0C0, pullUpEn);
        cfg(GPP_DRV_PULLDN, 1'b0, GPP_SENSE_BOTH, 8'h40);
        chk("pullDownEn", 12'h040, pullDownEn);
        chk("pullUpEn", 12'h080, pullUpEn);
        cfg(GPP_DRV_BUSKEEP, 1'b0, GPP_SENSE_BOTH, 8'h20);
        acc(`GPP_OPC_CLR_DIR, 8'h20, 8'h00);
        access.valid = 1'b0;
        step(3);
        chk("keepLow", 12'h001, {11'h0, pullDownEn[5]});
        acc(`GPP_OPC_SET_VAL, 8'h20, 8'h00);
        acc(`GPP_OPC_SET_DIR, 8'h20, 8'h00);
        access.valid = 1'b0;
        step(3);
        acc(`GPP_OPC_CLR_DIR, 8'h20, 8'h00);
        access.valid = 1'b0;
        step(3);
        chk("keepHigh", 12'h001, {11'h0, pullUpEn[5]});
    endtask
    task automatic t_sense();
        gpp_sense_t sn [4] = '{GPP_SENSE_BOTH, GPP_SENSE_RISE, GPP_SENSE_FALL, GPP_SENSE_RISE};
        logic [3:0] inv = 4'b1000, expR = 4'b0011, expF = 4'b1101;
        int n;
        cfg(GPP_DRV_TOTEM, 1'b0, GPP_SENSE_BOTH, 8'h80);
        irqMaskA = 8'h80;
        extVal[7] = 1'b1;
        step(2);
        chk("irqA", 12'h000, irqA);
        step(1);
        chk("irqA", 12'h001, irqA);
        chk("eventOut", 12'h080, eventOut);
        chk("irqB", 12'h000, irqB);
        step(1);
        chk("irqA", 12'h000, irqA);
        extVal[7] = 1'b0;
        for (int r = 0; r < 4; r++) begin
            cfg(GPP_DRV_TOTEM, inv[r], sn[r], 8'h80);
            extVal[7] = 1'b1;
            count(n);
            chk("riseHits", expR[r], n[11:0]);
            extVal[7] = 1'b0;
            count(n);
            chk("fallHits", expF[r], n[11:0]);
        end
        cfg(GPP_DRV_TOTEM, 1'b0, GPP_SENSE_LOW, 8'h80);
        chk("irqA", 12'h001, irqA);
        irqMaskA = 8'h00;
        irqMaskB = 8'h80;
        step(2);
        chk("irqA", 12'h000, irqA);
        chk("irqB", 12'h001, irqB);
        extVal[7] = 1'b1;
        step(4);
        chk("irqB", 12'h000, irqB);
        chk("inVal", 12'h080, inVal & 8'h80);
        clkActive = 1'b0;
        extVal[7] = 1'b0;
        step(2);
        chk("wake", 12'h001, wake);
        clkActive = 1'b1;
        step(1);
        chk("wakeOff", 12'h000, wake);
    endtask
    task automatic t_wired();
        cfg(GPP_DRV_WOR, 1'b0, GPP_SENSE_BOTH, 8'h0C);
        chk("worOe", 12'h004, pinOe & 8'h0C);
        cfg(GPP_DRV_WAND, 1'b0, GPP_SENSE_BOTH, 8'h0C);
        chk("wandOe", 12'h008, pinOe & 8'h0C);
        cfg(GPP_DRV_WOR_PD, 1'b0, GPP_SENSE_BOTH, 8'h0C);
        chk("worPull", 12'h00C, pullDownEn & 8'h0C);
        cfg(GPP_DRV_WAND_PU, 1'b0, GPP_SENSE_BOTH, 8'h0C);
        chk("wandPuOe", 12'h008, pinOe & 8'h0C);
        chk("wandPull", 12'h00C, pullUpEn & 8'h0C);
        cfg(GPP_DRV_TOTEM, 1'b1, GPP_SENSE_BOTH, 8'h0C);
        chk("invOut", 12'h008, pinOut & 8'h0C);
    endtask
    task automatic t_out();
        acc(`GPP_OPC_CLR_VAL, 8'h50, 8'h00);
        access.valid = 1'b0;
        altEn = 8'h40;
        altOut = 8'h40;
        altDirOut = 8'h40;
        step(1);
        chk("altPin", 12'h040, pinOut & 8'h40);
        chk("altOe", 12'h040, pinOe & 8'h40);
        altEn = 8'h00;
        clkOutPin = 3'h4;
        for (int k = 1; k < 4; k++) begin
            clkOutSel = gpp_clkout_t'(k);
            {eventIn, rtcClk, perClk} = 3'b001 << (k - 1);
            step(2);
            chk("clkOutHigh", 12'h010, pinOut & 8'h10);
            {eventIn, rtcClk, perClk} = ~(3'b001 << (k - 1));
            step(2);
            chk("clkOutLow", 12'h000, pinOut & 8'h10);
        end
        for (int k = 0; k < 4; k++) begin
            remapSel = k[1:0];
            step(1);
            chk("remapLoc", k[11:0], remapLoc);
        end
    endtask

    initial begin
        step(2);
        rst = 1'b0;
        t_basic();
        t_cfg();
        t_sense();
        t_out();
        t_wired();
        complete_run();
    end
    // whole run is well under 2000 cycles
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end
endmodule
